// File: dv/pic_cpu_model.sv
// cpu core side model: takes requests above its mask level and holds that level
`timescale 1ns/1ps
module pic_cpu_model (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       irq_req,
    input  wire logic [1:0] irq_level,
    input  wire logic [7:0] irq_vector,
    input  wire logic [1:0] base_mask,
    input  wire logic       svc_end,
    output logic      [1:0] cpu_mask_level,
    output logic      [7:0] taken_vector,
    output logic      [7:0] taken_cnt
);
    logic       in_svc;
    logic [1:0] held;

    // mask flags come up set after reset, as in the core
    assign cpu_mask_level = in_svc ? held : base_mask;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            in_svc       <= 1'h1;
            held         <= 2'h3;
            taken_vector <= 8'h00;
            taken_cnt    <= 8'h00;
        end else if (svc_end) begin
            in_svc <= 1'h0;
        end else if (irq_req && (irq_level > cpu_mask_level)) begin
            in_svc       <= 1'h1;
            held         <= irq_level;
            taken_vector <= irq_vector;
            taken_cnt    <= taken_cnt + 8'h01;
        end
    end
endmodule

// File: dv/tb_pic_ctrl.sv
// self-checking bench of the interrupt control registers
`timescale 1ns/1ps
module tb_pic_ctrl;
    logic                     clk_sys;
    logic                     resetn;
    logic [23:0]              io_addr;
    logic                     io_wr;
    logic                     io_rd;
    logic [7:0]               io_wdata;
    logic [pic_pkg::NSRC-1:0] src_event;
    logic [1:0]               cpu_mask_level;
    logic [7:0]               io_rdata;
    logic                     irq_req;
    logic [1:0]               irq_level;
    logic [7:0]               irq_vector;
    logic                     carrier_gen_on;
    logic                     carrier_force_on;
    logic [1:0]               base_mask;
    logic                     svc_end;
    logic [7:0]               taken_vector;
    logic [7:0]               taken_cnt;
    logic [7:0]               seen_cnt;
    logic [15:0]              l;
    logic [7:0]               also_pend;
    logic [7:0]               exp_ff [8];
    int                       miscompares;
    int                       checks_done;

    pic_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .src_event(src_event),
        .cpu_mask_level(cpu_mask_level), .io_rdata(io_rdata), .irq_req(irq_req),
        .irq_level(irq_level), .irq_vector(irq_vector), .carrier_gen_on(carrier_gen_on),
        .carrier_force_on(carrier_force_on));
    pic_cpu_model cpu (.clk_sys(clk_sys), .resetn(resetn), .irq_req(irq_req),
        .irq_level(irq_level), .irq_vector(irq_vector), .base_mask(base_mask),
        .svc_end(svc_end), .cpu_mask_level(cpu_mask_level), .taken_vector(taken_vector),
        .taken_cnt(taken_cnt));

    always #10 clk_sys = ~clk_sys;

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic wrap_up();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_addr  = {16'h00FF, a};
        io_wdata = d;
        io_wr    = 1'h1;
        @(negedge clk_sys);
        io_wr = 1'h0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        io_addr = {16'h00FF, a};
        io_rd   = 1'h1;
        @(negedge clk_sys);
        io_rd = 1'h0;
        chk(io_rdata, exp);
    endtask

    task automatic ev(input logic [pic_pkg::NSRC-1:0] m);
        @(negedge clk_sys);
        src_event = m;
        @(negedge clk_sys);
        src_event = '0;
    endtask

    // flag or enable place of a source: address byte, bit mask
    function automatic logic [15:0] loc(input int i, input logic fl);
        if (i < 8) return {fl ? 8'h25 : 8'h23, 8'h80 >> i};
        if (i < 15) return {fl ? 8'h24 : 8'h22, 8'h40 >> (i - 8)};
        return {fl ? 8'h27 : 8'h26, (i == 15) ? 8'h20 : (i == 16) ? 8'h80 : 8'h40};
    endfunction

    // wait for the cpu to take a request, then clear its flag and return
    task automatic svc(input logic [7:0] vec, input logic [7:0] lvl, input logic [15:0] fl);
        int k;
        k = 0;
        while (taken_cnt === seen_cnt && k < 30) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 30) begin
            miscompares++;
            wrap_up();
        end
        seen_cnt = taken_cnt;
        chk(taken_vector, vec);
        chk({6'h00, cpu_mask_level}, lvl);
        rdc(fl[15:8], fl[7:0] | also_pend);
        wr(fl[15:8], fl[7:0]);
        @(negedge clk_sys);
        svc_end = 1'h1;
        @(negedge clk_sys);
        svc_end = 1'h0;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        clk_sys = 1'h0; resetn = 1'h0; io_addr = 24'h000000; io_wr = 1'h0; io_rd = 1'h0;
        io_wdata = 8'h00; src_event = '0; base_mask = 2'h0; svc_end = 1'h0;
        miscompares = 0; checks_done = 0; seen_cnt = 8'h00;
        also_pend = 8'h00;
        exp_ff = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h00, 8'h00, 8'hF0, 8'h10};
        repeat (8) @(negedge clk_sys);
        resetn = 1'h1;
        svc_end = 1'h1;
        @(negedge clk_sys);
        svc_end = 1'h0;
        for (int a = 0; a < 9; a++) rdc(8'h20 + 8'(a), (a == 6) ? 8'h10 : 8'h00);
        chk({6'h00, carrier_gen_on, carrier_force_on}, 8'h02);
        for (int a = 0; a < 8; a++) wr(8'h20 + 8'(a), 8'hFF);
        for (int a = 0; a < 8; a++) rdc(8'h20 + 8'(a), exp_ff[a]);
        chk({6'h00, carrier_gen_on, carrier_force_on}, 8'h03);
        for (int a = 0; a < 8; a++) wr(8'h20 + 8'(a), 8'h00);
        ev('1);
        rdc(8'h24, 8'h7F);
        rdc(8'h25, 8'hFF);
        rdc(8'h27, 8'hE0);
        wr(8'h25, 8'h00);
        rdc(8'h25, 8'hFF);
        wr(8'h25, 8'h55);
        rdc(8'h25, 8'hAA);
        wr(8'h24, 8'h01);
        rdc(8'h24, 8'h7E);
        wr(8'h27, 8'h40);
        rdc(8'h27, 8'hA0);
        chk({7'h00, irq_req}, 8'h00);
        wr(8'h24, 8'hFF);
        wr(8'h25, 8'hFF);
        wr(8'h27, 8'hE0);
        rdc(8'h25, 8'h00);
        wr(8'h20, 8'hAA);
        wr(8'h21, 8'hAA);
        for (int i = 0; i < pic_pkg::NSRC; i++) begin
            l = loc(i, 1'h0);
            wr(l[15:8], l[7:0]);
            ev(18'h00001 << i);
            svc(8'h06 + 8'(2 * i), 8'h02, loc(i, 1'h1));
            wr(l[15:8], 8'h00);
        end
        wr(8'h22, 8'h7F);
        wr(8'h23, 8'hFF);
        wr(8'h26, 8'hE0);
        wr(8'h21, 8'h38);
        ev(18'h20001);
        svc(8'h28, 8'h03, loc(17, 1'h1));
        svc(8'h06, 8'h02, loc(0, 1'h1));
        ev(18'h00018);
        also_pend = 8'h08;
        svc(8'h0C, 8'h02, loc(3, 1'h1));
        also_pend = 8'h00;
        svc(8'h0E, 8'h02, loc(4, 1'h1));
        base_mask = 2'h2;
        ev(18'h00001);
        repeat (6) @(negedge clk_sys);
        chk({7'h00, irq_req}, 8'h00);
        base_mask = 2'h1;
        svc(8'h06, 8'h02, loc(0, 1'h1));
        wr(8'h23, 8'h00);
        ev(18'h00001);
        repeat (6) @(negedge clk_sys);
        chk({7'h00, irq_req}, 8'h00);
        wr(8'h23, 8'h80);
        svc(8'h06, 8'h02, loc(0, 1'h1));
        wrap_up();
    end
endmodule

// File: verilog/pic_arbiter.sv
// picks the request to present: highest level first, then fixed vector order
`timescale 1ns/1ps
module pic_arbiter #(
    parameter int NSRC = pic_pkg::NSRC
) (
    input  wire logic [NSRC-1:0]      pend,
    input  wire logic [NSRC-1:0][1:0] level,
    input  wire logic [1:0]           mask_level,
    output pic_pkg::pic_req_t         winner
);
    always_comb begin
        winner = '0;
        // walk from lowest to highest order so ties go to the lower index
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i] && (level[i] > mask_level) &&
                (!winner.valid || level[i] >= winner.level)) begin
                winner.valid  = 1'b1;
                winner.level  = level[i];
                winner.index  = 5'(i);
                winner.vector = pic_pkg::pic_vector(5'(i));
            end
        end
    end
endmodule

// File: verilog/pic_ctrl.sv
// interrupt priority, enable and factor flag registers with request output
// ************************************************************
// Operation
// - a two-bit level field reads 11 as level 3, 10 as 2, 01 as 1 and 00 as 0.
// - the first level register holds port-low-group, serial, stopwatch, clock timer fields.
// - the second level register holds carrier, timers 2-3, timers 0-1, port-high-group fields.
// - the first enable register holds stopwatch and clock timer enables in bits 6-0, bit 7 reads 0.
// - the second enable register holds timer 1/0, three port groups and three serial enables.
// - stopwatch and clock timer flags set on their event, clear on a written 1, ignore 0.
// - timer 1/0, port group and serial flags follow enable order and clear only on a written 1.
// - the third enable register holds timer 3, timer 2 and carrier enables in bits 7-5.
// - timer 3, timer 2 and carrier flags sit in bits 7-5, clear on a written 1, bits 3-0 read 0.
// - each source has a fixed vector, timer 1 first, timer 2 last, which breaks level ties.
// - among pending requests the one of highest priority is served first.
// ************************************************************
`timescale 1ns/1ps
module pic_ctrl (
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire logic [23:0]              io_addr,
    input  wire logic                     io_wr,
    input  wire logic                     io_rd,
    input  wire logic [7:0]               io_wdata,
    input  wire logic [pic_pkg::NSRC-1:0] src_event,
    input  wire logic [1:0]               cpu_mask_level,
    output logic      [7:0]               io_rdata,
    output logic                          irq_req,
    output logic      [1:0]               irq_level,
    output logic      [7:0]               irq_vector,
    output logic                          carrier_gen_on,
    output logic                          carrier_force_on
);

    // ************************************************************
    // register state
    // ************************************************************
    logic [7:0] priority_levels_a;
    logic [7:0] priority_levels_b;
    logic [6:0] timer_source_enables;
    logic [7:0] port_serial_enables;
    logic [6:0] timer_source_flags;
    logic [7:0] port_serial_flags;
    logic [2:0] upper_enables;
    logic [2:0] upper_flags;
    logic [6:0] next_timer_source_enables;
    logic [7:0] next_priority_levels_a;
    logic [7:0] next_priority_levels_b;
    logic [7:0] next_port_serial_enables;
    logic [6:0] next_timer_source_flags;
    logic [7:0] next_port_serial_flags;
    logic [2:0] next_upper_enables;
    logic [2:0] next_upper_flags;
    logic       next_carrier_gen_on;
    logic       next_carrier_force_on;
    logic [7:0] next_io_rdata;

    logic [pic_pkg::NSRC-1:0]      flag_vec;
    logic [pic_pkg::NSRC-1:0]      enable_vec;
    logic [pic_pkg::NSRC-1:0][1:0] level_vec;
    pic_pkg::pic_req_t             winner;

    // ************************************************************
    // source order: timer1, timer0, ports hi/mid/lo, serial err/rx/tx,
    // stopwatch 100/10/1, clock 32/8/2/1, carrier, timer3, timer2
    // ************************************************************
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            flag_vec[i]   = port_serial_flags[7 - i];
            enable_vec[i] = port_serial_enables[7 - i];
        end
        for (int i = 0; i < 7; i++) begin
            flag_vec[8 + i]   = timer_source_flags[6 - i];
            enable_vec[8 + i] = timer_source_enables[6 - i];
        end
        flag_vec[15]   = upper_flags[0];
        flag_vec[16]   = upper_flags[2];
        flag_vec[17]   = upper_flags[1];
        enable_vec[15] = upper_enables[0];
        enable_vec[16] = upper_enables[2];
        enable_vec[17] = upper_enables[1];
    end

    always_comb begin
        level_vec      = '0;
        level_vec[0]   = priority_levels_b[3:2];
        level_vec[1]   = priority_levels_b[3:2];
        level_vec[2]   = priority_levels_b[1:0];
        level_vec[3]   = priority_levels_a[7:6];
        level_vec[4]   = priority_levels_a[7:6];
        for (int i = 5; i < 8; i++) begin
            level_vec[i] = priority_levels_a[5:4];
        end
        for (int i = 8; i < 11; i++) begin
            level_vec[i] = priority_levels_a[3:2];
        end
        for (int i = 11; i < 15; i++) begin
            level_vec[i] = priority_levels_a[1:0];
        end
        level_vec[15]  = priority_levels_b[7:6];
        level_vec[16]  = priority_levels_b[5:4];
        level_vec[17]  = priority_levels_b[5:4];
    end

    pic_arbiter #(
        .NSRC       (pic_pkg::NSRC)
    ) u_arbiter (
        .pend       (flag_vec & enable_vec),
        .level      (level_vec),
        .mask_level (cpu_mask_level),
        .winner     (winner)
    );

    // ************************************************************
    // register writes, flag set/clear, read data
    // ************************************************************
    always_comb begin
        next_priority_levels_a    = priority_levels_a;
        next_priority_levels_b    = priority_levels_b;
        next_timer_source_enables = timer_source_enables;
        next_port_serial_enables  = port_serial_enables;
        next_upper_enables        = upper_enables;
        next_carrier_gen_on       = carrier_gen_on;
        next_carrier_force_on     = carrier_force_on;
        next_timer_source_flags   = timer_source_flags;
        next_port_serial_flags    = port_serial_flags;
        next_upper_flags          = upper_flags;
        if (io_wr) begin
            if (io_addr == pic_pkg::ADDR_PRIORITY_LEVELS_A) begin
                next_priority_levels_a = io_wdata;
            end else if (io_addr == pic_pkg::ADDR_PRIORITY_LEVELS_B) begin
                next_priority_levels_b = io_wdata;
            end else if (io_addr == pic_pkg::ADDR_TIMER_SOURCE_ENABLES) begin
                next_timer_source_enables = io_wdata[pic_pkg::TIMER_FIELD_MSB:0];
            end else if (io_addr == pic_pkg::ADDR_PORT_SERIAL_ENABLES) begin
                next_port_serial_enables = io_wdata;
            end else if (io_addr == pic_pkg::ADDR_TIMER_SOURCE_FLAGS) begin
                next_timer_source_flags = timer_source_flags &
                    ~io_wdata[pic_pkg::TIMER_FIELD_MSB:0];
            end else if (io_addr == pic_pkg::ADDR_PORT_SERIAL_FLAGS) begin
                next_port_serial_flags = port_serial_flags & ~io_wdata;
            end else if (io_addr == pic_pkg::ADDR_UPPER_ENABLES) begin
                next_upper_enables  = io_wdata[7:pic_pkg::UPPER_FIELD_LSB];
                next_carrier_gen_on = io_wdata[pic_pkg::CARRIER_CTRL_BIT];
            end else if (io_addr == pic_pkg::ADDR_UPPER_FLAGS) begin
                next_upper_flags      = upper_flags &
                    ~io_wdata[7:pic_pkg::UPPER_FIELD_LSB];
                next_carrier_force_on = io_wdata[pic_pkg::CARRIER_CTRL_BIT];
            end
        end
        // an event in the clearing cycle wins over the clear
        for (int i = 0; i < 8; i++) begin
            next_port_serial_flags[7 - i] = next_port_serial_flags[7 - i] | src_event[i];
        end
        for (int i = 0; i < 7; i++) begin
            next_timer_source_flags[6 - i] = next_timer_source_flags[6 - i] | src_event[8 + i];
        end
        next_upper_flags        = next_upper_flags |
            {src_event[16], src_event[17], src_event[15]};
    end

    always_comb begin
        next_io_rdata = io_rdata;
        if (io_rd) begin
            if (io_addr == pic_pkg::ADDR_PRIORITY_LEVELS_A) begin
                next_io_rdata = priority_levels_a;
            end else if (io_addr == pic_pkg::ADDR_PRIORITY_LEVELS_B) begin
                next_io_rdata = priority_levels_b;
            end else if (io_addr == pic_pkg::ADDR_TIMER_SOURCE_ENABLES) begin
                next_io_rdata = {1'b0, timer_source_enables};
            end else if (io_addr == pic_pkg::ADDR_PORT_SERIAL_ENABLES) begin
                next_io_rdata = port_serial_enables;
            end else if (io_addr == pic_pkg::ADDR_TIMER_SOURCE_FLAGS) begin
                next_io_rdata = {1'b0, timer_source_flags};
            end else if (io_addr == pic_pkg::ADDR_PORT_SERIAL_FLAGS) begin
                next_io_rdata = port_serial_flags;
            end else if (io_addr == pic_pkg::ADDR_UPPER_ENABLES) begin
                next_io_rdata = {upper_enables, carrier_gen_on, 4'h0};
            end else if (io_addr == pic_pkg::ADDR_UPPER_FLAGS) begin
                next_io_rdata = {upper_flags, carrier_force_on, 4'h0};
            end else begin
                next_io_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            priority_levels_a    <= pic_pkg::RST_ZERO;
            priority_levels_b    <= pic_pkg::RST_ZERO;
            timer_source_enables <= '0;
            port_serial_enables  <= pic_pkg::RST_ZERO;
            upper_enables        <= '0;
            timer_source_flags   <= '0;
            port_serial_flags    <= pic_pkg::RST_ZERO;
            upper_flags          <= '0;
            carrier_gen_on       <= pic_pkg::RST_CARRIER_GEN_ON;
            carrier_force_on     <= pic_pkg::RST_CARRIER_FORCE;
            io_rdata             <= pic_pkg::RST_ZERO;
        end else begin
            priority_levels_a    <= next_priority_levels_a;
            priority_levels_b    <= next_priority_levels_b;
            timer_source_enables <= next_timer_source_enables;
            port_serial_enables  <= next_port_serial_enables;
            upper_enables        <= next_upper_enables;
            timer_source_flags   <= next_timer_source_flags;
            port_serial_flags    <= next_port_serial_flags;
            upper_flags          <= next_upper_flags;
            carrier_gen_on       <= next_carrier_gen_on;
            carrier_force_on     <= next_carrier_force_on;
            io_rdata             <= next_io_rdata;
        end
    end

    // ************************************************************
    // request to the cpu
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irq_req    <= 1'b0;
            irq_level  <= 2'b00;
            irq_vector <= 8'h00;
        end else begin
            irq_req    <= winner.valid;
            irq_level  <= winner.level;
            irq_vector <= winner.vector;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [1:0] top_pending_level;
    always_comb begin
        top_pending_level = 2'b00;
        for (int i = 0; i < pic_pkg::NSRC; i++) begin
            if (flag_vec[i] && enable_vec[i] && level_vec[i] > top_pending_level) begin
                top_pending_level = level_vec[i];
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    flag_set_a: assert property ((src_event & ~flag_vec) != '0 |=>
        (flag_vec & $past(src_event)) == $past(src_event))
        else $error("event did not set its flag");
    zero_write_keeps_a: assert property (io_wr && io_wdata == 8'h00 &&
        io_addr == pic_pkg::ADDR_PORT_SERIAL_FLAGS && src_event[7:0] == 8'h00
        |=> port_serial_flags == $past(port_serial_flags))
        else $error("writing zero changed flags");
    w1c_clear_a: assert property (io_wr && io_addr == pic_pkg::ADDR_PORT_SERIAL_FLAGS &&
        src_event[7:0] == 8'h00 |=> (port_serial_flags & $past(io_wdata)) == 8'h00)
        else $error("written one did not clear flag");
    req_enabled_a: assert property (irq_req |-> $past(|(flag_vec & enable_vec)))
        else $error("request without enabled flag");
    req_above_mask_a: assert property (irq_req |-> irq_level > $past(cpu_mask_level))
        else $error("request not above mask level");
    highest_level_a: assert property (irq_req |-> irq_level == $past(top_pending_level))
        else $error("request not of highest pending level");
    vector_range_a: assert property (irq_req |-> irq_vector >= pic_pkg::VEC_BASE &&
        irq_vector <= pic_pkg::VEC_LAST && !irq_vector[0])
        else $error("vector out of range");
    prio_write_a: assert property (io_wr && io_addr == pic_pkg::ADDR_PRIORITY_LEVELS_A
        |=> priority_levels_a == $past(io_wdata))
        else $error("priority write lost");
    upper_read_zero_a: assert property (io_rd && (io_addr == pic_pkg::ADDR_UPPER_FLAGS ||
        io_addr == pic_pkg::ADDR_UPPER_ENABLES) |=> io_rdata[3:0] == 4'h0)
        else $error("reserved bits read nonzero");
    enable_bit7_a: assert property (io_rd && io_addr == pic_pkg::ADDR_TIMER_SOURCE_ENABLES
        |=> !io_rdata[7])
        else $error("bit 7 read nonzero");

endmodule

// File: verilog/pic_pkg.sv
// shared constants and request type of the peripheral interrupt control block
package pic_pkg;

    // ************************************************************
    // register map (cpu data space addresses)
    // ************************************************************
    localparam logic [23:0] ADDR_PRIORITY_LEVELS_A    = 24'h00FF20;
    localparam logic [23:0] ADDR_PRIORITY_LEVELS_B    = 24'h00FF21;
    localparam logic [23:0] ADDR_TIMER_SOURCE_ENABLES = 24'h00FF22;
    localparam logic [23:0] ADDR_PORT_SERIAL_ENABLES  = 24'h00FF23;
    localparam logic [23:0] ADDR_TIMER_SOURCE_FLAGS   = 24'h00FF24;
    localparam logic [23:0] ADDR_PORT_SERIAL_FLAGS    = 24'h00FF25;
    localparam logic [23:0] ADDR_UPPER_ENABLES        = 24'h00FF26;
    localparam logic [23:0] ADDR_UPPER_FLAGS          = 24'h00FF27;

    // ************************************************************
    // reset values and field layout
    // ************************************************************
    localparam logic [7:0] RST_ZERO           = 8'h00;
    localparam logic       RST_CARRIER_GEN_ON = 1'b1;
    localparam logic       RST_CARRIER_FORCE  = 1'b0;
    localparam int         TIMER_FIELD_MSB    = 6;
    localparam int         UPPER_FIELD_LSB    = 5;
    localparam int         CARRIER_CTRL_BIT   = 4;

    // ************************************************************
    // sources, in fixed vector order (index 0 is highest)
    // ************************************************************
    localparam int         NSRC       = 18;
    localparam logic [7:0] VEC_BASE   = 8'h06;
    localparam logic [7:0] VEC_LAST   = 8'h28;

    typedef struct packed {
        logic       valid;
        logic [1:0] level;
        logic [4:0] index;
        logic [7:0] vector;
    } pic_req_t;

    // vector address of a source index
    function automatic logic [7:0] pic_vector(input logic [4:0] idx);
        pic_vector = VEC_BASE + {2'b00, idx, 1'b0};
    endfunction

endpackage
